// >>> bus_match_fifo.sv
// bus-matching fifo from port a to port b with mailboxes
`timescale 1ns/1ps

// Notes on behaviour
// - long-word mode: whole word, same lanes
// - word mode: two halves, endian sets order
// - byte mode: four bytes, endian sets order
// - endian latched on first edge after reset release; sizes held static
// - unused port b lanes driven zero in narrow modes
// - fall-through: ready and data within three cycles
// - narrow modes: flags fall on final piece
// - standard: empty flag rises next cycle
// - fall-through: input ready rises after read
// - standard: full flag rises after read
// - space freed only by final piece read
// - almost-empty rises after write crossing threshold
// - almost-full rises after read crossing threshold
// - forward mailbox uses only low lanes in narrow modes, all lanes in long-word mode
// - return mailbox uses only low lanes in narrow modes, all lanes in long-word mode
// - mail write clears flag; blocks until read
// - memory holds full long words only
module bus_match_fifo
	import bus_match_fifo_pkg::*;
#(
	parameter int DEPTH     = bus_match_fifo_pkg::DEPTH_DEF,
	parameter int AE_OFFSET = bus_match_fifo_pkg::AE_OFFSET_DEF,
	parameter int AF_OFFSET = bus_match_fifo_pkg::AF_OFFSET_DEF
) (
	// clock and reset
	input  wire logic                                clk,
	input  wire logic                                rst_n,
	// configuration
	input  wire logic                                busMatchSelect,
	input  wire logic                                sizeSelect,
	input  wire logic                                endianSelect,
	input  wire logic                                fallThroughMode,
	// port a
	input  wire logic                                portAChipSelN,
	input  wire logic                                portADirection,
	input  wire logic                                portAEnable,
	input  wire logic                                portAMailboxSelect,
	input  wire logic [bus_match_fifo_pkg::LONG_W-1:0] portADataIn,
	output logic      [bus_match_fifo_pkg::LONG_W-1:0] portADataOut,
	output logic                                     portADataOe,
	// port b
	input  wire logic                                portBChipSelN,
	input  wire logic                                portBDirection,
	input  wire logic                                portBEnable,
	input  wire logic                                portBMailboxSelect,
	input  wire logic [bus_match_fifo_pkg::LONG_W-1:0] portBDataIn,
	output logic      [bus_match_fifo_pkg::LONG_W-1:0] portBDataOut,
	output logic                                     portBDataOe,
	// flags
	output logic                                     emptyFlag,
	output logic                                     outputReady,
	output logic                                     fullFlag,
	output logic                                     inputReady,
	output logic                                     almostEmptyN,
	output logic                                     almostFullN,
	output logic                                     forwardMailFlag,
	output logic                                     returnMailFlag
);

	// ----------------------------------------------------------------
	// sizes and checks
	// ----------------------------------------------------------------
	localparam int ADDR_W = $clog2(DEPTH);
	localparam int PTR_W  = ADDR_W + 1;

	initial begin
		if (DEPTH < 16 || (1 << ADDR_W) != DEPTH)
			$error("DEPTH must be a power of two of at least 16");
		if (AE_OFFSET < 1 || AE_OFFSET >= DEPTH || AF_OFFSET < 1 || AF_OFFSET >= DEPTH)
			$error("flag offsets must lie between 1 and DEPTH-1");
	end

	localparam logic [PTR_W-1:0] AE_LIMIT = PTR_W'(AE_OFFSET);
	localparam logic [PTR_W-1:0] AF_LIMIT = PTR_W'(DEPTH - AF_OFFSET);
	localparam logic [PTR_W-1:0] FULL_FILL = PTR_W'(DEPTH);
	localparam logic [PTR_W-1:0] PTR_ONE   = PTR_W'(1);

	// ----------------------------------------------------------------
	// state
	// ----------------------------------------------------------------
	typedef struct packed {
		logic [DEPTH-1:0][LONG_W-1:0] mem;
		logic [PTR_W-1:0]             wrPtr;
		logic [PTR_W-1:0]             rdPtr;
		logic [PTR_W-1:0]             wrPtrSeen;
		logic [PTR_W-1:0]             rdPtrSeen;
		logic                         cfgDone;
		bus_size_t                    busSize;
		logic                         bigEndian;
		logic                         fallThrough;
		logic [LONG_W-1:0]            hold;
		logic [1:0]                   piece;
		logic [LONG_W-1:0]            dataB;
		logic [LONG_W-1:0]            dataA;
		logic                         oeA;
		logic                         oeB;
		logic                         availFlag;
		logic                         spaceFlag;
		logic                         aeN;
		logic                         afN;
		logic [LONG_W-1:0]            fwdMail;
		logic [LONG_W-1:0]            retMail;
		logic                         fwdFlag;
		logic                         retFlag;
	} state_t;

	state_t s_r;
	state_t s_nxt;

	// ----------------------------------------------------------------
	// helpers
	// ----------------------------------------------------------------
	function automatic logic [LONG_W-1:0] laneMask(input bus_size_t sz);
		logic [LONG_W-1:0] m;
		m = MASK_LONG;
		unique case (sz)
			SIZE_LONG: m = MASK_LONG;
			SIZE_WORD: m = MASK_WORD;
			SIZE_BYTE: m = MASK_BYTE;
			default:   m = MASK_LONG;
		endcase
		return m;
	endfunction

	function automatic logic [1:0] lastPiece(input bus_size_t sz);
		logic [1:0] l;
		l = LAST_PIECE_LONG;
		unique case (sz)
			SIZE_LONG: l = LAST_PIECE_LONG;
			SIZE_WORD: l = LAST_PIECE_WORD;
			SIZE_BYTE: l = LAST_PIECE_BYTE;
			default:   l = LAST_PIECE_LONG;
		endcase
		return l;
	endfunction

	// piece idx of a long word, placed on the low lanes, rest zero
	function automatic logic [LONG_W-1:0] placePiece(input logic [LONG_W-1:0] w,
			input bus_size_t sz, input logic big, input logic [1:0] idx);
		logic [LONG_W-1:0] r;
		logic [1:0]        sel;
		r = w;
		sel = FIRST_PIECE;
		unique case (sz)
			SIZE_LONG: r = w;
			SIZE_WORD: begin
				sel = {1'b0, big ? ~idx[0] : idx[0]};
				r = (w >> (int'(sel) * WORD_W)) & MASK_WORD;
			end
			SIZE_BYTE: begin
				sel = big ? TOP_BYTE - idx : idx;
				r = (w >> (int'(sel) * BYTE_W)) & MASK_BYTE;
			end
			default: r = w;
		endcase
		return r;
	endfunction

	// ----------------------------------------------------------------
	// port strobes
	// ----------------------------------------------------------------
	logic aAccess;
	logic bAccess;
	logic wrFifo;
	logic wrFwdMail;
	logic rdRetMail;
	logic rdFifo;
	logic rdFwdMail;
	logic wrRetMail;
	logic isLast;

	assign aAccess   = !portAChipSelN && portAEnable && s_r.cfgDone;
	assign bAccess   = !portBChipSelN && portBEnable && s_r.cfgDone;
	assign wrFifo    = aAccess && portADirection && !portAMailboxSelect && s_r.spaceFlag;
	assign wrFwdMail = aAccess && portADirection && portAMailboxSelect && s_r.fwdFlag;
	assign rdRetMail = aAccess && !portADirection && portAMailboxSelect;
	assign rdFifo    = bAccess && portBDirection && !portBMailboxSelect && s_r.availFlag;
	assign rdFwdMail = bAccess && portBDirection && portBMailboxSelect;
	assign wrRetMail = bAccess && !portBDirection && portBMailboxSelect && s_r.retFlag;
	assign isLast    = (s_r.piece == lastPiece(s_r.busSize));

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		s_nxt = s_r;

		// configuration caught on the first edge after reset release
		if (!s_r.cfgDone) begin
			s_nxt.cfgDone     = 1'b1;
			s_nxt.bigEndian   = endianSelect;
			s_nxt.fallThrough = fallThroughMode;
			if (!busMatchSelect)
				s_nxt.busSize = SIZE_LONG;
			else if (sizeSelect)
				s_nxt.busSize = SIZE_BYTE;
			else
				s_nxt.busSize = SIZE_WORD;
		end

		// write side: whole long words only
		if (wrFifo) begin
			s_nxt.mem[s_r.wrPtr[ADDR_W-1:0]] = portADataIn;
			s_nxt.wrPtr = s_r.wrPtr + PTR_ONE;
		end
		s_nxt.wrPtrSeen = s_r.wrPtr;
		s_nxt.rdPtrSeen = s_r.rdPtr;

		// read side
		if (s_r.fallThrough) begin
			if (rdFifo) begin
				if (isLast) begin
					s_nxt.piece     = FIRST_PIECE;
					s_nxt.rdPtr     = s_r.rdPtr + PTR_ONE;
					s_nxt.availFlag = 1'b0;
				end else begin
					s_nxt.piece = s_r.piece + 2'h1;
					s_nxt.dataB = placePiece(s_r.hold, s_r.busSize, s_r.bigEndian,
						s_r.piece + 2'h1);
				end
			end
			// fetch once the current word is fully read
			if (!s_nxt.availFlag && s_r.wrPtrSeen != s_nxt.rdPtr) begin
				s_nxt.hold      = s_r.mem[s_nxt.rdPtr[ADDR_W-1:0]];
				s_nxt.dataB     = placePiece(s_nxt.hold, s_r.busSize, s_r.bigEndian,
					FIRST_PIECE);
				s_nxt.availFlag = 1'b1;
			end
		end else begin
			if (rdFifo) begin
				if (s_r.piece == FIRST_PIECE) begin
					s_nxt.hold  = s_r.mem[s_r.rdPtr[ADDR_W-1:0]];
					s_nxt.dataB = placePiece(s_nxt.hold, s_r.busSize, s_r.bigEndian,
						FIRST_PIECE);
				end else begin
					s_nxt.dataB = placePiece(s_r.hold, s_r.busSize, s_r.bigEndian,
						s_r.piece);
				end
				if (isLast) begin
					s_nxt.piece = FIRST_PIECE;
					s_nxt.rdPtr = s_r.rdPtr + PTR_ONE;
				end else begin
					s_nxt.piece = s_r.piece + 2'h1;
				end
			end
			s_nxt.availFlag = s_r.cfgDone && (s_r.wrPtr != s_nxt.rdPtr);
		end

		// space, almost-full and almost-empty flags, freed space only at final piece
		s_nxt.spaceFlag = s_r.cfgDone && (s_nxt.wrPtr - s_r.rdPtr != FULL_FILL);
		s_nxt.afN = s_r.cfgDone && (s_nxt.wrPtr - s_r.rdPtrSeen < AF_LIMIT);
		s_nxt.aeN = (s_r.wrPtrSeen - s_nxt.rdPtr > AE_LIMIT);

		// forward mailbox, a to b
		if (wrFwdMail) begin
			s_nxt.fwdMail = portADataIn & laneMask(s_r.busSize);
			s_nxt.fwdFlag = 1'b0;
		end else if (rdFwdMail) begin
			s_nxt.fwdFlag = 1'b1;
		end
		if (rdFwdMail)
			s_nxt.dataB = s_r.fwdMail & laneMask(s_r.busSize);

		// return mailbox, b to a
		if (wrRetMail) begin
			s_nxt.retMail = portBDataIn & laneMask(s_r.busSize);
			s_nxt.retFlag = 1'b0;
		end else if (rdRetMail) begin
			s_nxt.retFlag = 1'b1;
		end
		if (rdRetMail)
			s_nxt.dataA = s_r.retMail & laneMask(s_r.busSize);

		// output enables follow the read selection
		s_nxt.oeA = !portAChipSelN && !portADirection;
		s_nxt.oeB = !portBChipSelN && portBDirection;
	end

	// ----------------------------------------------------------------
	// state register
	// ----------------------------------------------------------------
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			s_r         <= '0;
			s_r.busSize <= SIZE_LONG;
			s_r.fwdFlag <= 1'b1;
			s_r.retFlag <= 1'b1;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------------------------------
	// outputs
	// ----------------------------------------------------------------
	assign portADataOut    = s_r.dataA;
	assign portADataOe     = s_r.oeA;
	assign portBDataOut    = s_r.dataB;
	assign portBDataOe     = s_r.oeB;
	assign emptyFlag       = s_r.availFlag;
	assign outputReady     = s_r.availFlag;
	assign fullFlag        = s_r.spaceFlag;
	assign inputReady      = s_r.spaceFlag;
	assign almostEmptyN    = s_r.aeN;
	assign almostFullN     = s_r.afN;
	assign forwardMailFlag = s_r.fwdFlag;
	assign returnMailFlag  = s_r.retFlag;

endmodule

// >>> bus_match_fifo_assertions.sv
// port-level checks for the bus-matching fifo
`timescale 1ns/1ps
module bus_match_fifo_assertions (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// configuration
	input wire logic busMatchSelect,
	input wire logic fallThroughMode,
	// port controls
	input wire logic portAChipSelN,
	input wire logic portADirection,
	input wire logic portAEnable,
	input wire logic portAMailboxSelect,
	input wire logic portBChipSelN,
	input wire logic portBDirection,
	input wire logic portBEnable,
	input wire logic portBMailboxSelect,
	// flags
	input wire logic emptyFlag,
	input wire logic outputReady,
	input wire logic fullFlag,
	input wire logic almostEmptyN,
	input wire logic almostFullN,
	input wire logic forwardMailFlag,
	input wire logic returnMailFlag
);
	// ----------------------------------------------------------------
	// access decode
	// ----------------------------------------------------------------
	logic aWr, bRd, bWr;
	logic [1:0] upCnt_r;
	assign aWr = !portAChipSelN && portAEnable && portADirection;
	assign bRd = !portBChipSelN && portBEnable && portBDirection;
	assign bWr = !portBChipSelN && portBEnable && !portBDirection;
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) upCnt_r <= 2'h0;
		else if (upCnt_r != 2'h3) upCnt_r <= upCnt_r + 2'h1;
	end
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	// ----------------------------------------------------------------
	// assertions
	// ----------------------------------------------------------------
	a_fwd_mail_set: assert property (aWr && portAMailboxSelect && forwardMailFlag
		|=> !forwardMailFlag) else $error("forward mail flag not cleared");
	a_fwd_mail_free: assert property (bRd && portBMailboxSelect && !forwardMailFlag
		|=> forwardMailFlag) else $error("forward mail flag not set");
	a_ret_mail_set: assert property (bWr && portBMailboxSelect && returnMailFlag
		|=> !returnMailFlag) else $error("return mail flag not cleared");
	a_mail_fall_cause: assert property ($fell(forwardMailFlag)
		|-> $past(aWr && portAMailboxSelect)) else $error("forward mail flag fell alone");
	a_empty_next: assert property (!fallThroughMode && aWr && !portAMailboxSelect
		&& fullFlag && !emptyFlag |-> ##2 emptyFlag) else $error("empty flag late");
	a_ready_soon: assert property (fallThroughMode && aWr && !portAMailboxSelect
		&& fullFlag && !outputReady |-> ##[1:3] outputReady) else $error("output ready late");
	a_full_next: assert property (!fallThroughMode && !busMatchSelect && bRd
		&& !portBMailboxSelect && emptyFlag && !fullFlag |-> ##2 fullFlag) else $error("full late");
	a_full_cause: assert property (!fallThroughMode && upCnt_r == 2'h3 && $rose(fullFlag)
		|-> $past(bRd && !portBMailboxSelect, 2)) else $error("space freed without read");
	a_empty_fall: assert property (busMatchSelect && $fell(emptyFlag)
		|-> $past(bRd && !portBMailboxSelect)) else $error("empty fell without read");
	a_ae_cause: assert property ($rose(almostEmptyN)
		|-> $past(aWr && !portAMailboxSelect, 3)) else $error("almost empty rose alone");
	a_af_cause: assert property (!fallThroughMode && upCnt_r == 2'h3 && $rose(almostFullN)
		|-> $past(bRd && !portBMailboxSelect, 3)) else $error("almost full rose alone");
endmodule

// >>> bus_match_fifo_pkg.sv
// constants and types shared by the bus-matching fifo read path
package bus_match_fifo_pkg;

	// ----------------------------------------------------------------
	// data widths
	// ----------------------------------------------------------------
	localparam int LONG_W = 36;
	localparam int WORD_W = 18;
	localparam int BYTE_W = 9;

	localparam logic [LONG_W-1:0] MASK_LONG = 36'hf_ffff_ffff;
	localparam logic [LONG_W-1:0] MASK_WORD = 36'h0_0003_ffff;
	localparam logic [LONG_W-1:0] MASK_BYTE = 36'h0_0000_01ff;

	// ----------------------------------------------------------------
	// depth and flag offsets
	// ----------------------------------------------------------------
	localparam int DEPTH_DEF     = 256;
	localparam int AE_OFFSET_DEF = 8;
	localparam int AF_OFFSET_DEF = 8;

	// ----------------------------------------------------------------
	// port b bus size and piece indices
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		SIZE_LONG = 3'h1,
		SIZE_WORD = 3'h2,
		SIZE_BYTE = 3'h4
	} bus_size_t;

	localparam logic [1:0] LAST_PIECE_LONG = 2'h0;
	localparam logic [1:0] LAST_PIECE_WORD = 2'h1;
	localparam logic [1:0] LAST_PIECE_BYTE = 2'h3;
	localparam logic [1:0] FIRST_PIECE     = 2'h0;
	localparam logic [1:0] TOP_BYTE        = 2'h3;

endpackage

// >>> bus_matching_fifo_read_path_tb.sv
// self-checking bench for the bus-matching fifo
`timescale 1ns/1ps
module bus_matching_fifo_read_path_tb;
	import bus_match_fifo_pkg::*;
	localparam int DEP = 16;
	logic clk = 1'b0, rst_n = 1'b0;
	logic busMatchSelect = 1'b0, sizeSelect = 1'b0, endianSelect = 1'b0, fallThroughMode = 1'b0;
	logic portBChipSelN = 1'b1, portBDirection = 1'b1, portBEnable = 1'b0;
	logic portBMailboxSelect = 1'b0;
	logic [35:0] portBDataIn = 36'h0, v;
	logic portAChipSelN, portADirection, portAEnable, portAMailboxSelect, portADataOe;
	logic [35:0] portADataIn, portADataOut, portBDataOut;
	logic portBDataOe, emptyFlag, outputReady, fullFlag, inputReady;
	logic almostEmptyN, almostFullN, forwardMailFlag, returnMailFlag;
	logic [3:0] cfg [6] = '{4'h0, 4'ha, 4'h9, 4'hf, 4'hc, 4'h1};
	int nFail = 0, nCompared = 0;
	always #25 clk = ~clk;
	bus_match_fifo #(.DEPTH(DEP)) dut_u (.*);
	// single device, no chain, one shared clock
	port_a_host hostU (.*);
	// ----------------------------------------------------------------
	// tasks
	// ----------------------------------------------------------------
	task automatic finalReport();
		$display("compared %0d mismatched %0d", nCompared, nFail);
		if (nFail == 0 && nCompared > 0) $display("== PASSED ==");
		else $display("== FAILED ==");
		$finish;
	endtask
	task automatic check(input logic [35:0] seen, input logic [35:0] exp);
		nCompared++;
		if (seen !== exp) begin
			nFail++;
			$display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic resetCfg(input logic [3:0] c);
		@(negedge clk);
		rst_n = 1'b0;
		{busMatchSelect, sizeSelect, endianSelect, fallThroughMode} = c;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		repeat (3) @(negedge clk);
	endtask
	task automatic waitData();
		int i;
		for (i = 0; i < 20 && emptyFlag !== 1'b1; i++) @(negedge clk);
		if (i == 20) begin
			nFail++;
			finalReport();
		end
	endtask
	// port b access: read fifo or mailbox, or write return mailbox
	task automatic busB(input logic wr, input logic mb, input logic [35:0] wd,
		output logic [35:0] d);
		@(negedge clk);
		if (fallThroughMode && !mb) d = portBDataOut;
		{portBChipSelN, portBEnable, portBDirection, portBMailboxSelect} = {2'b01, !wr, mb};
		portBDataIn = wd;
		@(negedge clk);
		{portBChipSelN, portBEnable} = 2'b10;
		portBDataIn = ~wd;
		if (!fallThroughMode || mb) d = portBDataOut;
	endtask
	task automatic pieceTest(input logic [3:0] c);
		int n;
		logic [35:0] d, m;
		resetCfg(c);
		n = !c[3] ? 1 : (c[2] ? 4 : 2);
		m = !c[3] ? MASK_LONG : (c[2] ? MASK_BYTE : MASK_WORD);
		d = 36'h9_a5c3_e17b;
		hostU.put(d, 1'b0);
		waitData();
		for (int i = 0; i < n; i++) begin
			busB(1'b0, 1'b0, 36'h0, v);
			check(v & m, (d >> (36 / n * (c[1] ? n - 1 - i : i))) & m);
			check(36'(emptyFlag), 36'(i != n - 1));
			check(36'(outputReady), 36'(i != n - 1));
			check(36'(portBDataOe), 36'h1);
		end
		hostU.put(~d, 1'b1);
		check(36'(forwardMailFlag), 36'h0);
		hostU.put(d, 1'b1);
		busB(1'b0, 1'b1, 36'h0, v);
		check(v & m, ~d & m);
		check(36'(forwardMailFlag), 36'h1);
		busB(1'b1, 1'b1, d, v);
		check(36'(returnMailFlag), 36'h0);
		hostU.get(v);
		check(v & m, d & m);
		check(36'(portADataOe), 36'h1);
		check(36'(returnMailFlag), 36'h1);
		$display("piece test cfg=%h done", c);
	endtask
	// ----------------------------------------------------------------
	// main sequence
	// ----------------------------------------------------------------
	initial begin
		for (int c = 0; c < 6; c++) pieceTest(cfg[c]);
		resetCfg(4'h0);
		for (int i = 0; i < DEP; i++) hostU.put(36'(i), 1'b0);
		@(negedge clk);
		check(36'(fullFlag), 36'h0);
		check(36'(inputReady), 36'h0);
		check(36'(almostFullN), 36'h0);
		check(36'(almostEmptyN), 36'h1);
		hostU.put(36'h0_dead_beef, 1'b0);
		busB(1'b0, 1'b0, 36'h0, v);
		check(v, 36'h0);
		@(negedge clk);
		check(36'(fullFlag), 36'h1);
		check(36'(inputReady), 36'h1);
		for (int i = 1; i < DEP; i++) begin
			busB(1'b0, 1'b0, 36'h0, v);
			check(v, 36'(i));
		end
		repeat (2) @(negedge clk);
		check(36'(emptyFlag), 36'h0);
		check(36'(almostFullN), 36'h1);
		check(36'(almostEmptyN), 36'h0);
		$display("fill test done");
		finalReport();
	end
endmodule
bind bus_match_fifo bus_match_fifo_assertions chkU (.*);

// >>> port_a_host.sv
// writing host model on port a
`timescale 1ns/1ps
module port_a_host (
	// clock
	input wire logic         clk,
	// port a
	output logic             portAChipSelN,
	output logic             portADirection,
	output logic             portAEnable,
	output logic             portAMailboxSelect,
	output logic      [35:0] portADataIn,
	input  wire logic [35:0] portADataOut
);
	initial begin
		portAChipSelN = 1'b1;
		portADirection = 1'b1;
		portAEnable = 1'b0;
		portAMailboxSelect = 1'b0;
		portADataIn = 36'h0;
	end
	// one write, fifo or forward mailbox; bus shows inverse when idle
	task automatic put(input logic [35:0] d, input logic mb);
		@(negedge clk);
		{portAChipSelN, portAEnable, portADirection, portAMailboxSelect} = {3'b011, mb};
		portADataIn = d;
		@(negedge clk);
		{portAChipSelN, portAEnable} = 2'b10;
		portADataIn = ~d;
	endtask
	// one return mailbox read
	task automatic get(output logic [35:0] d);
		@(negedge clk);
		{portAChipSelN, portAEnable, portADirection, portAMailboxSelect} = 4'b0101;
		@(negedge clk);
		{portAChipSelN, portAEnable} = 2'b10;
		d = portADataOut;
	endtask
endmodule
